// *** core/ispsl_pkg.sv ***
package ispsl_pkg;
  // ******************************************************
  // Command opcodes and second bytes
  // ******************************************************
  localparam logic [7:0] OP_ENABLE      = 8'hAC;
  localparam logic [7:0] SUB_PROG_EN    = 8'h53;
  localparam logic [7:0] SUB_PAR_EN     = 8'h35;
  localparam logic [7:0] OP_CHIP_ERASE  = 8'h8A;
  localparam logic [7:0] OP_RD_STATUS   = 8'h60;
  localparam logic [7:0] OP_LOAD_BUF    = 8'h51;
  localparam logic [7:0] OP_WR_CODE     = 8'h50;
  localparam logic [7:0] OP_WR_CODE_AE  = 8'h70;
  localparam logic [7:0] OP_RD_CODE     = 8'h30;
  localparam logic [7:0] OP_WR_DATA     = 8'hD0;
  localparam logic [7:0] OP_WR_DATA_AE  = 8'hD2;
  localparam logic [7:0] OP_RD_DATA     = 8'hB0;
  localparam logic [7:0] OP_WR_FUSE     = 8'hE1;
  localparam logic [7:0] OP_WR_FUSE_AE  = 8'hF1;
  localparam logic [7:0] OP_RD_FUSE     = 8'h61;
  localparam logic [7:0] OP_WR_LOCK     = 8'hE4;
  localparam logic [7:0] OP_RD_LOCK     = 8'h64;
  localparam logic [7:0] OP_WR_USIG     = 8'h52;
  localparam logic [7:0] OP_WR_USIG_AE  = 8'h72;
  localparam logic [7:0] OP_RD_USIG     = 8'h32;
  localparam logic [7:0] OP_RD_MSIG     = 8'h38;
  // ******************************************************
  // Status register fields
  // ******************************************************
  localparam int STAT_BUSY_N  = 0;
  localparam int STAT_WRITE_INHIBIT_FLAG  = 1;
  localparam int STAT_SUCCESS = 2;
  localparam int STAT_LOAD    = 3;
  localparam logic [7:0] STAT_UNUSED_MASK = 8'h0F;
  localparam logic [7:0] ERASED_BYTE      = 8'hFF;
  localparam logic [7:0] MSB_MASK         = 8'h80;
  // ******************************************************
  // Packet layout
  // ******************************************************
  localparam int BYTE_OPCODE   = 0;
  localparam int BYTE_ADDR_HI  = 1;
  localparam int BYTE_ADDR_LO  = 2;
  localparam int BYTE_DATA0    = 3;
  localparam int PAGE_BYTES    = 64;
  localparam int BADDR_W       = 6;
  localparam int HALF_BIT      = 6;
  localparam int PAGE_LSB_BIT  = 7;
  localparam logic [2:0] DATA_HI_ZERO = 3'h0;
  // ******************************************************
  // Cycle timing
  // ******************************************************
  localparam real CLK_NS       = 50.0;
  localparam real T_WR_MS      = 2.5;
  localparam real T_AWR_MS     = 5.0;
  localparam real T_ERS_MS     = 7.5;
  localparam int  WR_CYC       = int'(T_WR_MS * 1.0e6 / CLK_NS);
  localparam int  AWR_CYC      = int'(T_AWR_MS * 1.0e6 / CLK_NS);
  localparam int  ERS_CYC      = int'(T_ERS_MS * 1.0e6 / CLK_NS);
  localparam int  CNT_W        = 24;
  typedef enum logic [1:0] {
    ISPSL_IDLE  = 2'b00,
    ISPSL_PROG  = 2'b01,
    ISPSL_INH   = 2'b10
  } ispsl_prog_e;
endpackage : ispsl_pkg

// *** core/ispsl_sync.sv ***
`timescale 1ns/10ps
// Two-flop level synchroniser
module ispsl_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  // ******************************************************
  // Double register
  // ******************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ispsl_sync

// *** core/ispsl_link.sv ***
`timescale 1ns/10ps
// Link-side shifter on the programmer clock; one byte per toggle
module ispsl_link (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       par_mode,
  input  wire logic       mosi,
  input  wire logic [7:0] pbus_in,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output logic            rx_tgl,
  output logic            miso,
  output logic [7:0]      pbus_out
);
  logic [2:0] bit_cnt_reg;
  logic [6:0] sh_reg;
  logic [7:0] tx_sh_reg;
  // ******************************************************
  // Receive shift, MSB first on rising SCK
  // ******************************************************
  // rising edge sampling
  always_ff @(posedge sck or posedge ss_n)
  begin
    if (ss_n)
    begin
      bit_cnt_reg <= 3'h0;
      sh_reg      <= 7'h00;
      rx_tgl      <= 1'b0;
      rx_byte     <= 8'h00;
    end
    else if (par_mode)
    begin
      if (mosi)
      begin
        rx_byte <= pbus_in;
        rx_tgl  <= ~rx_tgl;
      end
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      sh_reg      <= {sh_reg[5:0], mosi};
      if (bit_cnt_reg == 3'h7)
      begin
        rx_byte <= {sh_reg, mosi};
        rx_tgl  <= ~rx_tgl;
      end
    end
  end
  // ******************************************************
  // Transmit on falling SCK
  // ******************************************************
  // falling edge output
  always_ff @(negedge sck or posedge ss_n)
  begin
    if (ss_n)
    begin
      tx_sh_reg <= 8'h00;
      miso      <= 1'b0;
      pbus_out  <= 8'h00;
    end
    else
    begin
      pbus_out <= tx_byte;
      if (bit_cnt_reg == 3'h0)
      begin
        miso      <= tx_byte[7];
        tx_sh_reg <= {tx_byte[6:0], 1'b0};
      end
      else
      begin
        miso      <= tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
    end
  end
endmodule : ispsl_link

// *** core/ispsl_top.sv ***
`timescale 1ns/10ps
// Functional notes
// - program enable AC 53 must come first before other commands
// - AC 35 switches to parallel bytes until reset pin released
// - page commands take 1 to 64 bytes, address advances
// - fuse and lock bytes map one bit each, data 00h or FFh
// - code opcodes 50, 70, 30 with two address bytes
// - data opcodes D0, D2, B0; top three high address bits zero
// - fuse opcodes E1, F1, 61, lock E4, 64
// - user signature opcodes 52, 72, 32
// - maker signature page read via opcode 38
// - load buffer 51 clears status bit 3; next write sets it
// - read status 60 returns the status byte
// - opcode 8A starts chip erase lasting 7.5 ms
// - low address byte holds page bit, half select, six byte bits
// - status bit 2 cleared at cycle start, set if no brownout
// - brownout clears status bit 1 and spoils success
// - status bit 0 low while busy or inhibited
// - polled byte reads with MSB inverted while programming
// - erase polling returns 7FH until done
// - MSB first, mode 0, sample rising, drive falling
// - select low frames a command; done when select rises
// - byte address wraps inside the half page
// - parallel mode: MOSI low is output enable for byte port
module ispsl_top
  import ispsl_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  input  wire logic       SCK_LINK,
  input  wire logic       SS_N,
  input  wire logic       MOSI,
  input  wire logic       RST_PIN,
  input  wire logic       BROWNOUT_DETECTOR,
  input  wire logic [7:0] PBUS_IN,
  output logic            MISO,
  output logic            MISO_OE,
  output logic [7:0]      PBUS_OUT,
  output logic            PBUS_OE,
  output logic            IN_SYSTEM_PROGRAMMING_MODE,
  output logic            PAR_MODE,
  output logic            MEM_WE,
  output logic [15:0]     MEM_ADDR,
  output logic [7:0]      MEM_WDATA,
  output logic [7:0]      MEM_CMD,
  output logic            MEM_ERASE,
  input  wire logic [7:0] MEM_RDATA
);
  import ispsl_pkg::*;
  // ******************************************************
  // Declarations
  // ******************************************************
  logic [7:0]  rx_byte;
  logic        rx_tgl;
  logic        miso_l;
  logic [7:0]  pbus_l;
  logic [7:0]  tx_reg;
  logic        tgl_s;
  logic        tgl_d_reg;
  logic        ss_s;
  logic        rst_pin_s;
  logic        bod_s;
  logic        mosi_s;
  logic        par_reg;
  logic        en_reg;
  logic [7:0]  op_reg;
  logic [7:0]  ahi_reg;
  logic [7:0]  alo_reg;
  logic [7:0]  bidx_reg;
  logic [7:0]  status_reg;
  logic [7:0]  poll_reg;
  logic        wr_pend_reg;
  logic [7:0]  last_byte_reg;
  ispsl_prog_e prog_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cyc_len_reg;
  logic        bod_hit_reg;
  logic        rx_evt;
  logic        ss_rise;
  logic        ss_d_reg;
  logic        is_wr_op;
  logic        is_rd_op;
  logic        is_ae_op;
  logic        busy;
  // Byte address increment with half-page wrap
  function automatic logic [7:0] ispsl_wrap_inc(input logic [7:0] a);
    ispsl_wrap_inc = {a[7:BADDR_W], a[BADDR_W-1:0] + 6'h01};
  endfunction : ispsl_wrap_inc
  // ******************************************************
  // Link domain and crossings
  // ******************************************************
  ispsl_link u_link (
    .sck      (SCK_LINK),
    .ss_n     (SS_N),
    .par_mode (par_reg),
    .mosi     (MOSI),
    .pbus_in  (PBUS_IN),
    .tx_byte  (tx_reg),
    .rx_byte  (rx_byte),
    .rx_tgl   (rx_tgl),
    .miso     (miso_l),
    .pbus_out (pbus_l)
  );
  ispsl_sync u_s_tgl (.clk(CLK_SYS), .rst(SYS_RST), .d(rx_tgl), .q(tgl_s));
  ispsl_sync u_s_ss  (.clk(CLK_SYS), .rst(SYS_RST), .d(~SS_N), .q(ss_s));
  ispsl_sync u_s_rst (.clk(CLK_SYS), .rst(SYS_RST), .d(RST_PIN), .q(rst_pin_s));
  ispsl_sync u_s_bod (.clk(CLK_SYS), .rst(SYS_RST), .d(BROWNOUT_DETECTOR), .q(bod_s));
  ispsl_sync u_s_oe  (.clk(CLK_SYS), .rst(SYS_RST), .d(MOSI), .q(mosi_s));
  // rx_byte is stable for a whole byte time once the toggle is seen
  assign rx_evt  = tgl_s ^ tgl_d_reg;
  assign ss_rise = ss_d_reg & ~ss_s;
  assign busy    = (prog_reg != ISPSL_IDLE);
  assign is_ae_op = (op_reg == OP_WR_CODE_AE) || (op_reg == OP_WR_DATA_AE)
                 || (op_reg == OP_WR_FUSE_AE) || (op_reg == OP_WR_USIG_AE);
  assign is_wr_op = is_ae_op || (op_reg == OP_WR_CODE) || (op_reg == OP_WR_DATA)
                 || (op_reg == OP_WR_FUSE) || (op_reg == OP_WR_LOCK)
                 || (op_reg == OP_WR_USIG);
  assign is_rd_op = (op_reg == OP_RD_CODE) || (op_reg == OP_RD_DATA)
                 || (op_reg == OP_RD_FUSE) || (op_reg == OP_RD_LOCK)
                 || (op_reg == OP_RD_USIG) || (op_reg == OP_RD_MSIG);
  // Edge history
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      tgl_d_reg <= 1'b0;
      ss_d_reg  <= 1'b0;
    end
    else
    begin
      tgl_d_reg <= tgl_s;
      ss_d_reg  <= ss_s;
    end
  end
  // ******************************************************
  // Session mode: enable and parallel
  // ******************************************************
  // enable gate
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || !rst_pin_s)
    begin
      en_reg  <= 1'b0;
      par_reg <= 1'b0;
    end
    else if (rx_evt && bidx_reg == BYTE_ADDR_HI[7:0] && op_reg == OP_ENABLE)
    begin
      if (rx_byte == SUB_PROG_EN)
        en_reg <= 1'b1;
      else if (rx_byte == SUB_PAR_EN && en_reg)
        par_reg <= 1'b1;
    end
  end
  // ******************************************************
  // Packet parser
  // ******************************************************
  // byte address advances
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || !ss_s)
    begin
      bidx_reg      <= 8'h00;
      op_reg        <= 8'h00;
      ahi_reg       <= 8'h00;
      alo_reg       <= 8'h00;
      wr_pend_reg   <= 1'b0;
      last_byte_reg <= 8'h00;
    end
    else if (rx_evt)
    begin
      if (bidx_reg < BYTE_DATA0[7:0])
        bidx_reg <= bidx_reg + 8'h01;
      if (bidx_reg == BYTE_OPCODE[7:0])
        op_reg <= rx_byte;
      else if (bidx_reg == BYTE_ADDR_HI[7:0])
        ahi_reg <= rx_byte;
      else if (bidx_reg == BYTE_ADDR_LO[7:0])
        alo_reg <= rx_byte;
      else
      begin
        alo_reg <= ispsl_wrap_inc(alo_reg);
        if (en_reg && is_wr_op)
        begin
          wr_pend_reg   <= 1'b1;
          last_byte_reg <= rx_byte;
        end
      end
    end
  end
  // ******************************************************
  // Memory port: one strobe per data byte
  // ******************************************************
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= 16'h0000;
      MEM_WDATA <= 8'h00;
      MEM_CMD   <= 8'h00;
    end
    else
    begin
      MEM_WE <= rx_evt && en_reg && ss_s && bidx_reg >= BYTE_DATA0[7:0]
                && (is_wr_op || op_reg == OP_LOAD_BUF)
                && !(op_reg == OP_WR_DATA && ahi_reg[7:5] != DATA_HI_ZERO)
                && !(op_reg == OP_WR_DATA_AE && ahi_reg[7:5] != DATA_HI_ZERO);
      MEM_ADDR  <= {ahi_reg, alo_reg};
      MEM_WDATA <= rx_byte;
      MEM_CMD   <= op_reg;
    end
  end
  // ******************************************************
  // Programming cycle timer
  // ******************************************************
  // erase start
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      prog_reg    <= ISPSL_IDLE;
      cnt_reg     <= '0;
      cyc_len_reg <= '0;
      bod_hit_reg <= 1'b0;
      MEM_ERASE   <= 1'b0;
    end
    else
    begin
      MEM_ERASE <= 1'b0;
      case (prog_reg)
        ISPSL_IDLE:
        begin
          if (ss_rise && en_reg && op_reg == OP_CHIP_ERASE && !bod_s)
          begin
            prog_reg    <= ISPSL_PROG;
            cyc_len_reg <= CNT_W'(ERS_CYC);
            cnt_reg     <= '0;
            bod_hit_reg <= 1'b0;
            MEM_ERASE   <= 1'b1;
          end
          else if (ss_rise && wr_pend_reg && !bod_s)
          begin
            prog_reg    <= ISPSL_PROG;
            cyc_len_reg <= is_ae_op ? CNT_W'(AWR_CYC) : CNT_W'(WR_CYC);
            cnt_reg     <= '0;
            bod_hit_reg <= 1'b0;
          end
        end
        ISPSL_PROG:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (bod_s)
            bod_hit_reg <= 1'b1;
          if (cnt_reg == cyc_len_reg - 1'b1)
            prog_reg <= ISPSL_IDLE;
        end
        default:
          prog_reg <= ISPSL_IDLE;
      endcase
    end
  end
  // ******************************************************
  // Status register and polled byte
  // ******************************************************
  // load flag
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      status_reg <= 8'h00;
      poll_reg   <= ERASED_BYTE;
    end
    else
    begin
      status_reg[7:4] <= 4'h0;
      status_reg[STAT_WRITE_INHIBIT_FLAG] <= !bod_s;
      status_reg[STAT_BUSY_N] <= !busy && !bod_s;
      if (prog_reg == ISPSL_IDLE && ss_rise && en_reg && !bod_s
          && (wr_pend_reg || op_reg == OP_CHIP_ERASE))
      begin
        status_reg[STAT_SUCCESS] <= 1'b0;
        status_reg[STAT_LOAD]    <= 1'b1;
        poll_reg <= (op_reg == OP_CHIP_ERASE) ? ERASED_BYTE : last_byte_reg;
      end
      else if (prog_reg == ISPSL_PROG && cnt_reg == cyc_len_reg - 1'b1)
        status_reg[STAT_SUCCESS] <= !bod_hit_reg && !bod_s;
      if (rx_evt && en_reg && bidx_reg == BYTE_ADDR_LO[7:0] && op_reg == OP_LOAD_BUF)
        status_reg[STAT_LOAD] <= 1'b0;
    end
  end
  // ******************************************************
  // Read-back byte into the link
  // ******************************************************
  // status out
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      tx_reg <= 8'h00;
    else if (en_reg && op_reg == OP_RD_STATUS)
      tx_reg <= status_reg & STAT_UNUSED_MASK;
    else if (en_reg && is_rd_op && busy)
      tx_reg <= poll_reg ^ MSB_MASK;
    else if (en_reg && is_rd_op)
      tx_reg <= MEM_RDATA;
    else
      tx_reg <= 8'h00;
  end
  // ******************************************************
  // Pin drivers
  // ******************************************************
  // parallel output enable
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      MISO     <= 1'b0;
      MISO_OE  <= 1'b0;
      PBUS_OUT <= 8'h00;
      PBUS_OE  <= 1'b0;
      IN_SYSTEM_PROGRAMMING_MODE <= 1'b0;
      PAR_MODE <= 1'b0;
    end
    else
    begin
      MISO     <= miso_l;
      MISO_OE  <= ss_s && !par_reg && rst_pin_s;
      PBUS_OUT <= pbus_l;
      PBUS_OE  <= ss_s && par_reg && !mosi_s;
      IN_SYSTEM_PROGRAMMING_MODE <= rst_pin_s;
      PAR_MODE <= par_reg;
    end
  end
  // ******************************************************
  // Checks
  // ******************************************************
  property p_erase_len;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    MEM_ERASE |=> busy [*8];
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase ended early");
  property p_busy_flag;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    busy |=> !status_reg[STAT_BUSY_N];
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("busy flag high");
  property p_bod_inh;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    bod_s |=> !status_reg[STAT_WRITE_INHIBIT_FLAG];
  endproperty
  a_bod_inh: assert property (p_bod_inh) else $error("inhibit not cleared");
  property p_upper_zero;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (en_reg && op_reg == OP_RD_STATUS) |=> tx_reg[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_success_clr;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(busy) |-> !status_reg[STAT_SUCCESS];
  endproperty
  a_success_clr: assert property (p_success_clr) else $error("success left high");
  property p_no_we_unen;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !en_reg |=> !MEM_WE;
  endproperty
  a_no_we_unen: assert property (p_no_we_unen) else $error("write before enable");
  property p_poll;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (en_reg && is_rd_op && busy && op_reg != OP_RD_STATUS) |=> tx_reg == ($past(poll_reg) ^ MSB_MASK);
  endproperty
  a_poll: assert property (p_poll) else $error("polling byte wrong");
  property p_par_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (par_reg && rst_pin_s) |=> par_reg;
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parallel mode lost");
  c_erase: cover property (@(posedge CLK_SYS) MEM_ERASE);
  c_write: cover property (@(posedge CLK_SYS) MEM_WE);
  c_par:   cover property (@(posedge CLK_SYS) $rose(par_reg));
endmodule : ispsl_top

// *** tb/ispsl_prog_model.sv ***
`timescale 1ns/10ps
// ****************************************
// Programmer model: master of the link
// ****************************************
module ispsl_prog_model #(
  parameter int HALF_TICKS = 35
) (
  output logic     SCK_LINK,
  output logic     SS_N,
  output logic     MOSI,
  input wire logic MISO
);
  logic lclk = 1'b0;

  // Link tick of 12 ns, phase unrelated to the system clock
  always #6 lclk = ~lclk;

  initial
  begin
    SCK_LINK = 1'b0;
    SS_N = 1'b1;
    MOSI = 1'b0;
  end

  // Wait a number of link ticks
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask : tick

  task automatic xbyte(input logic [7:0] b, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      MOSI <= b[i];
      tick(HALF_TICKS);
      q[i] = MISO;
      SCK_LINK <= 1'b1;
      tick(HALF_TICKS);
      SCK_LINK <= 1'b0;
    end
    // Halves are stretched so the slave answer is current
    tick(2 * HALF_TICKS);
  endtask : xbyte

  task automatic cmd(input logic [7:0] op, hi, lo, d, input int n, output logic [7:0] r);
    logic [7:0] q;
    SS_N <= 1'b0;
    tick(HALF_TICKS);
    xbyte(op, q);
    xbyte(hi, q);
    xbyte(lo, q);
    r = 8'h00;
    for (int k = 0; k < n; k++)
    begin
      xbyte(d, q);
      if (k == 0)
        r = q;
    end
    tick(HALF_TICKS);
    SS_N <= 1'b1;
    // released data line stops holding its last bit
    MOSI <= ~MOSI;
    tick(4 * HALF_TICKS);
  endtask : cmd
endmodule : ispsl_prog_model

// *** tb/testbench.sv ***
`timescale 1ns/10ps
// ****************************************
// Bench: programming session on the slave
// ****************************************
module testbench;
  import ispsl_pkg::*;
  logic        CLK_SYS = 1'b0;
  logic        SYS_RST, RST_PIN, BROWNOUT_DETECTOR, SCK_LINK, SS_N, MOSI, MISO, MISO_OE;
  logic        PBUS_OE, IN_SYSTEM_PROGRAMMING_MODE, PAR_MODE, MEM_WE, MEM_ERASE;
  logic [7:0]  PBUS_IN, MEM_RDATA, PBUS_OUT, MEM_WDATA, MEM_CMD, r, last_cmd;
  logic [15:0] MEM_ADDR, last_addr;
  logic [7:0]  mem [0:255];
  int          n_fail = 0, n_tests = 0, n_we = 0, n_ers = 0, cyc = 0;

  always #25 CLK_SYS = ~CLK_SYS;
  assign MEM_RDATA = mem[MEM_ADDR[7:0]];

  ispsl_top u_dut (.CLK_SYS, .SYS_RST, .SCK_LINK, .SS_N, .MOSI, .RST_PIN, .BROWNOUT_DETECTOR,
    .PBUS_IN, .MISO, .MISO_OE, .PBUS_OUT, .PBUS_OE, .IN_SYSTEM_PROGRAMMING_MODE, .PAR_MODE,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_CMD, .MEM_ERASE, .MEM_RDATA);

  ispsl_prog_model u_prog (.SCK_LINK, .SS_N, .MOSI, .MISO);

  // Memory stand-in; counts strobes and cuts a hang short
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (MEM_WE === 1'b1)
    begin
      n_we++;
      last_addr = MEM_ADDR;
      last_cmd  = MEM_CMD;
      mem[MEM_ADDR[7:0]] <= MEM_WDATA;
    end
    if (MEM_ERASE === 1'b1)
      n_ers++;
    if (cyc == 95000)
    begin
      n_fail++;
      $display("ERROR at %0t: timeout", $time);
      conclude();
    end
  end

  // Compare one value and count it
  task automatic check(input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : settle

  // One framed command; r holds the first answer byte
  task automatic c(input logic [7:0] op, hi, lo, d, input int n);
    u_prog.cmd(op, hi, lo, d, n, r);
    settle(10);
  endtask : c

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    SYS_RST = 1'b1;
    RST_PIN = 1'b0;
    BROWNOUT_DETECTOR = 1'b0;
    PBUS_IN = 8'h00;
    foreach (mem[i]) mem[i] = 8'hA5;
    repeat (12) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    settle(2);
    check({MEM_WE, MEM_ERASE, PAR_MODE, IN_SYSTEM_PROGRAMMING_MODE, 4'h0}, 8'h00);
    // session pin held high from here
    RST_PIN <= 1'b1;
    settle(10);
    check({6'h00, IN_SYSTEM_PROGRAMMING_MODE, MISO_OE}, 8'h02);
    c(OP_LOAD_BUF, 8'h00, 8'h10, 8'h22, 1);
    check(8'(n_we), 8'h00);
    $display("refusal test done");
    c(OP_ENABLE, SUB_PROG_EN, 8'h00, 8'h00, 0);
    c(OP_LOAD_BUF, 8'h00, 8'h3F, 8'h11, 2);
    check(8'(n_we), 8'h02);
    check(last_addr[7:0], 8'h00);
    c(OP_RD_STATUS, 8'h00, 8'h00, 8'h00, 1);
    check(r & 8'hFB, 8'h03);
    $display("load test done");
    c(OP_WR_CODE, 8'h01, 8'h45, 8'h3C, 1);
    check(last_cmd, OP_WR_CODE);
    check(last_addr[15:8], 8'h01);
    check(last_addr[7:0], 8'h45);
    c(OP_RD_STATUS, 8'h00, 8'h00, 8'h00, 1);
    check(r & 8'h0D, 8'h08);
    c(OP_RD_CODE, 8'h01, 8'h45, 8'h00, 1);
    check(r, 8'hBC);
    // poll until the write cycle is over
    for (int k = 0; k < 30 && r[0] !== 1'b1; k++)
    begin
      settle(2000);
      c(OP_RD_STATUS, 8'h00, 8'h00, 8'h00, 1);
    end
    check(r & 8'h0F, 8'h0F);
    c(OP_RD_CODE, 8'h01, 8'h45, 8'h00, 1);
    check(r, 8'h3C);
    $display("write test done");
    BROWNOUT_DETECTOR <= 1'b1;
    settle(10);
    c(OP_RD_STATUS, 8'h00, 8'h00, 8'h00, 1);
    check(r & 8'h03, 8'h00);
    BROWNOUT_DETECTOR <= 1'b0;
    settle(10);
    $display("brownout test done");
    c(OP_CHIP_ERASE, 8'h00, 8'h00, 8'h00, 0);
    check(8'(n_ers), 8'h01);
    c(OP_RD_CODE, 8'h01, 8'h45, 8'h00, 1);
    check(r, 8'h7F);
    c(OP_RD_STATUS, 8'h00, 8'h00, 8'h00, 1);
    check(r & 8'h05, 8'h00);
    $display("erase test done");
    c(OP_ENABLE, SUB_PAR_EN, 8'h00, 8'h00, 0);
    check({7'h00, PAR_MODE}, 8'h01);
    check({7'h00, PBUS_OE}, 8'h00);
    // exit with clock low and data released
    RST_PIN <= 1'b0;
    settle(10);
    check({7'h00, PAR_MODE}, 8'h00);
    $display("parallel test done");
    conclude();
  end
endmodule : testbench
